// [rtl/reset_and_low_power_sequencer.v]
// Reset sequencer, reset-source status and stop/halt control for a small microcontroller
`include "rst_lp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module reset_and_low_power_sequencer #(
  parameter [6:0] POWERUP_CYCLES = `POWERUP_RC_CYCLES,
  parameter [4:0] SETTLE_CLOCKS  = `OSC_SETTLE_CLOCKS,
  parameter [2:0] PIN_CLOCKS     = `PIN_FILTER_CLOCKS,
  parameter [3:0] OPTION_CLOCKS  = `OPTION_LOAD_CLOCKS
) (
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  input  wire        supply_good_i,
  input  wire        supply_droop_detector_i,
  input  wire        dog_osc_i,
  input  wire        dog_timeout_i,
  input  wire        reset_pin_n_i,
  input  wire        stop_instr_i,
  input  wire        halt_instr_i,
  input  wire        stop_recovery_i,
  input  wire        wake_i,
  input  wire        droop_detect_in_stop_option_i,
  input  wire        dog_timeout_reset_select_i,
  input  wire        dog_stop_enable_i,
  input  wire        status_clear_i,
  output reg         sys_reset_o,
  output reg         option_load_o,
  output reg         fetch_reset_vector_o,
  output wire [15:0] reset_vector_o,
  output reg         powerup_status_o,
  output reg         dog_status_o,
  output reg         stop_mode_o,
  output reg         halt_mode_o,
  output wire        sys_clk_run_o,
  output wire        cpu_run_o,
  output wire        crystal_enable_o,
  output wire        osc_in_drive_o,
  output wire        osc_in_oe_o,
  output wire        osc_out_drive_o,
  output wire        osc_out_oe_o,
  output wire        dog_run_o,
  output wire        droop_detect_enable_o,
  output wire        peripheral_idle_o
);

  localparam [4:0] ST_POWERUP = 5'h01;
  localparam [4:0] ST_SETTLE  = 5'h02;
  localparam [4:0] ST_OPTION  = 5'h04;
  localparam [4:0] ST_RUN     = 5'h08;
  localparam [4:0] ST_STOP    = 5'h10;

  reg  [4:0] state;
  reg  [4:0] next_state;
  reg  [6:0] rc_count;
  reg  [4:0] settle_count;
  reg  [3:0] option_count;
  reg  [2:0] pin_count;
  reg        pin_reset;
  reg        dog_osc_q1;
  reg        dog_osc_q2;
  reg        dog_osc_q3;
  reg        powerup_cause;
  reg        dog_cause;
  wire       rc_edge;
  wire       droop_active;
  wire       dog_reset;
  wire       warm_reset;
  wire       restart;

  localparam [6:0] RC_LAST     = POWERUP_CYCLES - 7'd1;
  localparam [4:0] SETTLE_LAST = SETTLE_CLOCKS - 5'd1;
  localparam [3:0] OPTION_LAST = OPTION_CLOCKS - 4'd1;

  // True in the states that hold the chip in reset
  function is_reset_state;
    input [4:0] st;
    begin
      is_reset_state = (st == ST_POWERUP) || (st == ST_SETTLE) || (st == ST_OPTION);
    end
  endfunction

  // True on the edge that leaves option load for normal running
  function is_release;
    input [4:0] st;
    input [4:0] nxt;
    begin
      is_release = (st == ST_OPTION) && (nxt == ST_RUN);
    end
  endfunction

  // Dog oscillator sampled through two flops, edge taken after them
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dog_osc_q1 <= 1'b0;
      dog_osc_q2 <= 1'b0;
      dog_osc_q3 <= 1'b0;
    end else begin
      dog_osc_q1 <= dog_osc_i;
      dog_osc_q2 <= dog_osc_q1;
      dog_osc_q3 <= dog_osc_q2;
    end
  end
  assign rc_edge = dog_osc_q2 & ~dog_osc_q3;

  // Droop detector only counts when enabled for the current mode
  assign droop_detect_enable_o = (state != ST_STOP) | droop_detect_in_stop_option_i;
  assign droop_active = supply_droop_detector_i & droop_detect_enable_o;

  // Dog timeout resets only in normal or halt mode
  assign dog_reset = dog_timeout_i & dog_timeout_reset_select_i & (state == ST_RUN);

  // Pin filter: low for the full count before a reset is accepted
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_count <= 3'h0;
      pin_reset <= 1'b0;
    end else if (reset_pin_n_i) begin
      pin_count <= 3'h0;
      pin_reset <= 1'b0;
    end else if (pin_count < PIN_CLOCKS) begin
      pin_count <= pin_count + 3'h1;
      pin_reset <= (pin_count + 3'h1 == PIN_CLOCKS);
    end
  end

  assign warm_reset = dog_reset | pin_reset;
  assign restart    = ~supply_good_i | droop_active;

  // Sequencer
  always @* begin
    next_state = state;
    case (state)
      // Wait for the power-up count on dog oscillator edges
      ST_POWERUP: begin
        if (supply_good_i && !droop_active && rc_edge && rc_count == RC_LAST) begin
          next_state = ST_SETTLE;
        end
      end
      // Let the crystal settle
      ST_SETTLE: begin
        if (settle_count == SETTLE_LAST) begin
          next_state = ST_OPTION;
        end
      end
      // Load option bits, held while a pin reset stands
      ST_OPTION: begin
        if (option_count == OPTION_LAST && !pin_reset) begin
          next_state = ST_RUN;
        end
      end
      // Normal and halt operation
      ST_RUN: begin
        if (stop_instr_i) begin
          next_state = ST_STOP;
        end
      end
      // Clocks stopped until recovery
      ST_STOP: begin
        if (stop_recovery_i) begin
          next_state = ST_OPTION;
        end
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
    if (restart) begin
      next_state = ST_POWERUP;
    end else if (warm_reset && state != ST_POWERUP && state != ST_SETTLE) begin
      next_state = ST_OPTION;
    end
  end

  // State register
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  // Power-up counter; any supply loss starts it again from zero
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_count <= 7'h00;
    end else if (restart || state != ST_POWERUP || next_state != ST_POWERUP) begin
      rc_count <= 7'h00;
    end else if (rc_edge) begin
      rc_count <= rc_count + 7'd1;
    end
  end

  // Oscillator settle counter
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_count <= 5'h00;
    end else if (state != ST_SETTLE || next_state != ST_SETTLE) begin
      settle_count <= 5'h00;
    end else begin
      settle_count <= settle_count + 5'd1;
    end
  end

  // Option load counter; restarts while a pin reset is still held
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      option_count <= 4'h0;
    end else if (state != ST_OPTION || next_state != ST_OPTION || warm_reset) begin
      option_count <= 4'h0;
    end else if (option_count != OPTION_LAST) begin
      option_count <= option_count + 4'd1;
    end
  end

  // Combined system reset
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= is_reset_state(next_state);
    end
  end

  // Option load strobe
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      option_load_o <= 1'b0;
    end else begin
      option_load_o <= (next_state == ST_OPTION);
    end
  end

  // Reset-vector fetch pulse on release
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_reset_vector_o <= 1'b0;
    end else begin
      fetch_reset_vector_o <= is_release(state, next_state);
    end
  end
  assign reset_vector_o = `RESET_VECTOR_ADDR;

  // Reset-cause memory, cleared once the chip runs again
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      powerup_cause <= 1'b1;
      dog_cause     <= 1'b0;
    end else begin
      if (state == ST_POWERUP) begin
        powerup_cause <= 1'b1;
      end else if (state == ST_RUN) begin
        powerup_cause <= 1'b0;
      end
      if (dog_reset) begin
        dog_cause <= 1'b1;
      end else if (state == ST_RUN) begin
        dog_cause <= 1'b0;
      end
    end
  end

  // Status flags; a new cause wins over a clear
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      powerup_status_o <= 1'b0;
      dog_status_o     <= 1'b0;
    end else begin
      if (is_release(state, next_state) && powerup_cause) begin
        powerup_status_o <= 1'b1;
      end else if (status_clear_i) begin
        powerup_status_o <= 1'b0;
      end
      if (is_release(state, next_state) && dog_cause) begin
        dog_status_o <= 1'b1;
      end else if (status_clear_i) begin
        dog_status_o <= 1'b0;
      end
    end
  end

  // Stop mode flag
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_mode_o <= 1'b0;
    end else begin
      stop_mode_o <= (next_state == ST_STOP);
    end
  end

  // Halt mode flag, left on wake or on any state change
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_mode_o <= 1'b0;
    end else if (next_state != ST_RUN || wake_i) begin
      halt_mode_o <= 1'b0;
    end else if (halt_instr_i && !stop_instr_i) begin
      halt_mode_o <= 1'b1;
    end
  end

  // Clock and oscillator control in stop; halt keeps the crystal on
  assign sys_clk_run_o     = ~stop_mode_o;
  assign cpu_run_o         = ~stop_mode_o & ~halt_mode_o & ~sys_reset_o;
  assign crystal_enable_o  = ~stop_mode_o;
  assign osc_in_drive_o    = 1'b1;
  assign osc_in_oe_o       = stop_mode_o;
  assign osc_out_drive_o   = 1'b0;
  assign osc_out_oe_o      = stop_mode_o;
  assign dog_run_o         = ~stop_mode_o | dog_stop_enable_i;
  assign peripheral_idle_o = stop_mode_o;

endmodule // reset_and_low_power_sequencer
`default_nettype wire

// [rtl/rst_lp_regs.vh]
// Timing counts and constants for the reset and low-power sequencer
`ifndef RST_LP_REGS_VH
`define RST_LP_REGS_VH
`define POWERUP_RC_CYCLES   7'd66
`define OSC_SETTLE_CLOCKS   5'd16
`define PIN_FILTER_CLOCKS   3'd4
`define OPTION_LOAD_CLOCKS  4'd4
`define RESET_VECTOR_ADDR   16'h0002
`endif

// [verif/reset_and_low_power_sequencer_bench.sv]
// Self-checking bench for the reset and low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_low_power_sequencer_bench;
  logic sys_clk_i = 0, arst_n_i = 0, stop_instr_i = 0, halt_instr_i = 0, stop_recovery_i = 0;
  logic wake_i = 0, droop_detect_in_stop_option_i = 1, dog_timeout_reset_select_i = 1;
  logic dog_stop_enable_i = 1, status_clear_i = 0, pwr = 1, brown = 0, fire = 0, pin_low = 0;
  wire supply_good_i, supply_droop_detector_i, dog_osc_i, dog_timeout_i, reset_pin_n_i;
  wire sys_reset_o, option_load_o, fetch_reset_vector_o, powerup_status_o, dog_status_o;
  wire stop_mode_o, halt_mode_o, sys_clk_run_o, cpu_run_o, crystal_enable_o, osc_in_drive_o;
  wire osc_in_oe_o, osc_out_drive_o, osc_out_oe_o, dog_run_o, droop_detect_enable_o;
  wire peripheral_idle_o;
  wire [15:0] reset_vector_o;
  int err_count = 0, num_checks = 0;
  reset_and_low_power_sequencer reset_and_low_power_sequencer_inst (.*);
  supply_dog_pin_model supply_dog_pin_model_inst (.clk_i(sys_clk_i), .power_on_i(pwr),
    .brown_i(brown), .fire_i(fire), .pin_low_i(pin_low), .good_o(supply_good_i),
    .droop_o(supply_droop_detector_i), .osc_o(dog_osc_i), .pin_n_o(reset_pin_n_i),
    .timeout_o(dog_timeout_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Waits for reset release and checks its distance and the vector fetch
  task automatic rel(input int lo, hi);
    int n;
    n = 0;
    while (sys_reset_o !== 1'b0 && n < 400) begin
      look(1);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h1);
    chk({fetch_reset_vector_o, reset_vector_o[14:0]}, 16'h8002);
  endtask
  task pin_test;
    @(posedge sys_clk_i) pin_low <= 1'b1;
    cyc(3);
    pin_low <= 1'b0;
    look(6);
    chk(sys_reset_o, 1'b0);
    @(posedge sys_clk_i) pin_low <= 1'b1;
    cyc(6);
    pin_low <= 1'b0;
    rel(3, 7);
    chk(dog_status_o, 1'b0);
  endtask
  task dog_test;
    @(posedge sys_clk_i) fire <= 1'b1;
    @(posedge sys_clk_i) fire <= 1'b0;
    look(3);
    rel(1, 6);
    chk(dog_status_o, 1'b1);
    @(posedge sys_clk_i) dog_timeout_reset_select_i <= 1'b0;
    fire <= 1'b1;
    @(posedge sys_clk_i) fire <= 1'b0;
    status_clear_i <= 1'b1;
    @(posedge sys_clk_i) status_clear_i <= 1'b0;
    dog_timeout_reset_select_i <= 1'b1;
    look(4);
    chk({sys_reset_o, powerup_status_o, dog_status_o}, 3'b000);
  endtask
  // Clocked from the own oscillator, so stop is allowed
  task stop_test;
    @(posedge sys_clk_i) stop_instr_i <= 1'b1;
    @(posedge sys_clk_i) stop_instr_i <= 1'b0;
    look(2);
    chk({stop_mode_o, sys_clk_run_o, cpu_run_o, crystal_enable_o}, 4'b1000);
    chk({osc_in_drive_o, osc_in_oe_o, osc_out_drive_o, osc_out_oe_o}, 4'b1101);
    chk({dog_run_o, droop_detect_enable_o, peripheral_idle_o}, 3'b111);
    @(posedge sys_clk_i) dog_stop_enable_i <= 1'b0;
    droop_detect_in_stop_option_i <= 1'b0;
    look(1);
    chk({dog_run_o, droop_detect_enable_o}, 2'b00);
    @(posedge sys_clk_i) dog_stop_enable_i <= 1'b1;
    droop_detect_in_stop_option_i <= 1'b1;
    @(posedge sys_clk_i) fire <= 1'b1;
    @(posedge sys_clk_i) fire <= 1'b0;
    look(4);
    chk({stop_mode_o, sys_reset_o}, 2'b10);
    @(posedge sys_clk_i) stop_recovery_i <= 1'b1;
    @(posedge sys_clk_i) stop_recovery_i <= 1'b0;
    look(2);
    chk({stop_mode_o, sys_reset_o}, 2'b01);
    rel(1, 6);
    @(posedge sys_clk_i) halt_instr_i <= 1'b1;
    @(posedge sys_clk_i) halt_instr_i <= 1'b0;
    look(2);
    chk({halt_mode_o, crystal_enable_o}, 2'b11);
    @(posedge sys_clk_i) wake_i <= 1'b1;
    @(posedge sys_clk_i) wake_i <= 1'b0;
    look(2);
    chk(halt_mode_o, 1'b0);
  endtask
  task droop_test;
    @(posedge sys_clk_i) brown <= 1'b1;
    look(30);
    chk(sys_reset_o, 1'b1);
    @(posedge sys_clk_i) brown <= 1'b0;
    cyc(100);
    brown <= 1'b1;
    cyc(2);
    brown <= 1'b0;
    rel(280, 300);
    chk(powerup_status_o, 1'b1);
  endtask
  initial begin
    cyc(20);
    arst_n_i <= 1'b1;
    rel(280, 300);
    chk(powerup_status_o, 1'b1);
    pin_test;
    dog_test;
    stop_test;
    droop_test;
    test_done;
  end
  initial begin
    cyc(2000);
    err_count++;
    test_done;
  end
endmodule // reset_and_low_power_sequencer_bench
`default_nettype wire

// [verif/reset_and_low_power_sequencer_checker.sv]
// Port-level checks for the reset and low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_low_power_sequencer_checker (
  input wire logic sys_clk_i, arst_n_i, supply_droop_detector_i, dog_timeout_i, reset_pin_n_i,
  input wire logic stop_recovery_i, droop_detect_in_stop_option_i, dog_timeout_reset_select_i,
  input wire logic dog_stop_enable_i, supply_good_i, sys_reset_o, option_load_o, cpu_run_o,
  input wire logic fetch_reset_vector_o, stop_mode_o, halt_mode_o, sys_clk_run_o, dog_run_o,
  input wire logic crystal_enable_o, osc_in_drive_o, osc_in_oe_o, osc_out_drive_o, osc_out_oe_o,
  input wire logic droop_detect_enable_o, peripheral_idle_o,
  input wire logic [15:0] reset_vector_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  pin_filter_a: assert property (!reset_pin_n_i [*4] |-> ##[1:2] sys_reset_o)
    else $error("pin reset missed");
  dog_reset_a: assert property (dog_timeout_i && dog_timeout_reset_select_i && !sys_reset_o
    && !stop_mode_o |-> ##[1:2] sys_reset_o) else $error("dog reset missed");
  droop_reset_a: assert property (supply_droop_detector_i && !stop_mode_o |-> ##[1:2] sys_reset_o)
    else $error("droop reset missed");
  stop_clock_a: assert property (stop_mode_o |-> !sys_clk_run_o && !cpu_run_o)
    else $error("clock runs in stop");
  stop_pins_a: assert property (stop_mode_o |-> !crystal_enable_o && osc_in_drive_o
    && osc_in_oe_o && !osc_out_drive_o && osc_out_oe_o) else $error("stop pins wrong");
  stop_power_a: assert property (stop_mode_o |-> dog_run_o == dog_stop_enable_i
    && droop_detect_enable_o == droop_detect_in_stop_option_i && peripheral_idle_o)
    else $error("stop power wrong");
  stop_exit_a: assert property (stop_mode_o && !stop_recovery_i && supply_good_i
    && !supply_droop_detector_i && reset_pin_n_i && $past(reset_pin_n_i) |=> stop_mode_o)
    else $error("stop left early");
  halt_xtal_a: assert property (halt_mode_o |-> crystal_enable_o)
    else $error("crystal off in halt");
  release_a: assert property ($fell(sys_reset_o) |-> fetch_reset_vector_o
    && reset_vector_o == 16'h0002 && $past(option_load_o)) else $error("bad release");
  cover property ($fell(sys_reset_o));
  cover property ($rose(stop_mode_o));
  cover property ($rose(halt_mode_o));
endmodule // reset_and_low_power_sequencer_checker
bind reset_and_low_power_sequencer reset_and_low_power_sequencer_checker checker_inst (.*);
`default_nettype wire

// [verif/supply_dog_pin_model.sv]
// Supply monitor, dog timer and reset pin model
`timescale 1ns/1ps
`default_nettype none
module supply_dog_pin_model (
  input  wire logic clk_i, power_on_i, brown_i, fire_i, pin_low_i,
  output wire logic good_o, droop_o, osc_o, pin_n_o, timeout_o
);
  logic [1:0] div = 2'h0;
  logic       fired = 1'b0;
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    fired <= fire_i;
  end
  assign osc_o = div[1];
  assign timeout_o = fired;
  assign good_o = power_on_i & ~brown_i;
  assign droop_o = brown_i;
  assign pin_n_o = ~pin_low_i;
endmodule // supply_dog_pin_model
`default_nettype wire
